//--- console_pkg.sv
package console_pkg;

  // ----------------------------------------------------------------
  // widths and constants
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC =
    (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DB_W        = 20;
  localparam int unsigned NUM_SW      = 3;
  // switch indices inside the debouncer
  localparam int unsigned SW_STEP     = 0;
  localparam int unsigned SW_ACLR     = 1;
  localparam int unsigned SW_PWRON    = 2;
  localparam int unsigned LOAD_DIG_W  = 3;
  localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;
  localparam logic [3:0] STATUS_INIT  = 4'h0;

  // register display selector
  typedef enum logic [1:0] {
    SEL_B = 2'b00,
    SEL_A = 2'b01,
    SEL_I = 2'b11,
    SEL_P = 2'b10
  } reg_sel_t;

  // step sequencer, gray along idle -> issue -> wait; wait -> idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b11,
    ST_INIT  = 2'b10
  } step_state_t;

endpackage

//--- switch_if.sv
`timescale 1ns/1ps
interface switch_if;
  import console_pkg::*;
  logic [NUM_SW-1:0] raw;
  logic [NUM_SW-1:0] level;
  logic [NUM_SW-1:0] press;
  modport filter (input raw, output level, output press);
  modport user (output raw, input level, input press);
endinterface

//--- switch_debounce.sv
`timescale 1ns/1ps
module switch_debounce
  import console_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // switches
  switch_if.filter  sw
);
  import console_pkg::*;

  logic [NUM_SW-1:0] sync1_q;
  logic [NUM_SW-1:0] sync2_q;
  logic [NUM_SW-1:0] level_q;
  logic [NUM_SW-1:0] press_q;
  logic [DB_W-1:0]   cnt_q [NUM_SW];

  // --------------------------------------------------------------
  // two-stage sync; the first stage feeds only the second
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sw.raw;
      sync2_q <= sync1_q;
    end
  end

  // --------------------------------------------------------------
  // a level must hold steady for the whole window before it counts
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_q <= '0;
      press_q <= '0;
      for (int i = 0; i < NUM_SW; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_SW; i++) begin
        press_q[i] <= 1'b0;
        if (sync2_q[i] == level_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == DB_W'(DEBOUNCE_CYC - 1)) begin
          cnt_q[i]   <= '0;
          level_q[i] <= sync2_q[i];
          press_q[i] <= sync2_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign sw.level = level_q;
  assign sw.press = press_q;

endmodule

//--- console_control.sv
`timescale 1ns/1ps
// Overview of operation
// - manual mode: one instruction per step press
// - automatic mode: run instructions continuously
// - stall lamp on timeout; trap, init, lockout clear
// - lockout toggle inhibits interrupts and watchdog while the enable key is on
// - general alarm is OR of seven alarms
// - alarm clear, manual only, clears held alarms
// - heat lamp warns; power shutdown only at trip
// - stale lamp during multiply/divide/table ops
// - buffer lamp: io error sets; jump/clear resets
// - A select shows loaded memory word
// - save-I: step shows next location, I holds address
// - loader digit in B bits 0-2, auto loads
// - manual step with B selected and save-I off executes word held in B
// - power-on button, manual only, applies power, initializes
// - initialize clears registers, alarms; sets status 1
module console_control
  import console_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // operator switches
  input  wire logic              console_enable_key,
  input  wire logic              run_step_toggle,
  input  wire logic              step_button,
  input  wire logic              alarm_clear_button,
  input  wire logic              power_on_button,
  input  wire logic              interrupt_lockout_toggle,
  input  wire logic              save_i_switch,
  input  wire logic              loader_select_switch,
  input  wire logic [1:0]        reg_select_in,
  input  wire logic              reg_select_strobe,
  input  wire logic [WORD_W-1:0] entry_bits,
  input  wire logic              entry_strobe,
  // processor status
  input  wire logic              instr_done,
  input  wire logic              watchdog_expired,
  input  wire logic              trap_save_and_branch_op,
  input  wire logic              jump_no_error_op,
  input  wire logic              mul_div_table_op,
  input  wire logic              temp_warning,
  input  wire logic              airflow_low,
  input  wire logic              temp_trip,
  input  wire logic              watchdog_trap,
  input  wire logic              stall_alarm,
  input  wire logic              core_parity_error,
  input  wire logic              core_temp_alarm,
  input  wire logic              io_alarm,
  input  wire logic              io_buffer_error,
  input  wire logic [WORD_W-1:0] a_reg_value,
  input  wire logic [WORD_W-1:0] p_reg_value,
  input  wire logic [ADDR_W-1:0] mem_addr_value,
  // processor control
  output logic                   run_enable,
  output logic                   step_pulse,
  output logic                   execute_b_word,
  output logic [WORD_W-1:0]      b_reg,
  output logic [WORD_W-1:0]      i_reg,
  output logic                   initialize_pulse,
  output logic                   dc_power_on,
  output logic                   interrupt_enable,
  output logic                   watchdog_enable,
  output logic                   interrupt_permit_flag,
  output logic [4:0]             status_bits,
  output logic                   alarm_clear_pulse,
  output logic                   loader_start,
  // lamps
  output logic [WORD_W-1:0]      display_lamps,
  output logic [1:0]             reg_select_lamps,
  output logic                   interrupt_stall_lamp,
  output logic                   general_alarm_lamp,
  output logic                   cabinet_heat_lamp,
  output logic                   instr_reg_stale_lamp,
  output logic                   io_buffer_lamp
);
  import console_pkg::*;

  switch_if sw ();

  step_state_t state_q;
  reg_sel_t    sel_q;
  logic        auto_mode;
  logic        lockout;
  logic        core_parity_q;
  logic        io_alarm_q;
  logic        auto_prev_q;

  // --------------------------------------------------------------
  // switch conditioning
  // --------------------------------------------------------------
  assign sw.raw[SW_STEP]  = step_button;
  assign sw.raw[SW_ACLR]  = alarm_clear_button;
  assign sw.raw[SW_PWRON] = power_on_button;

  switch_debounce u_debounce (
    .clk     (clk),
    .reset_n (reset_n),
    .sw      (sw)
  );

  // --------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------
  // a disabled console must never leave the plant halted
  assign auto_mode = !console_enable_key || run_step_toggle;
  assign lockout   = console_enable_key && interrupt_lockout_toggle;

  function automatic logic manual_press(input logic p,
                                        input logic am);
    return p && !am;
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_enable       <= 1'b0;
      interrupt_enable <= 1'b0;
      watchdog_enable  <= 1'b0;
    end else begin
      run_enable       <= auto_mode;
      interrupt_enable <= !lockout;
      watchdog_enable  <= !lockout;
    end
  end

  // --------------------------------------------------------------
  // power-on and initialize
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dc_power_on      <= 1'b0;
      initialize_pulse <= 1'b0;
    end else begin
      initialize_pulse <= 1'b0;
      if (temp_trip) begin
        dc_power_on <= 1'b0;
      end else if (manual_press(sw.press[SW_PWRON], auto_mode)) begin
        dc_power_on      <= 1'b1;
        initialize_pulse <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // step sequencer; one instruction per debounced press
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q        <= ST_IDLE;
      step_pulse     <= 1'b0;
      execute_b_word <= 1'b0;
    end else begin
      step_pulse     <= 1'b0;
      execute_b_word <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (initialize_pulse) begin
            state_q <= ST_INIT;
          end else if (manual_press(sw.press[SW_STEP], auto_mode)) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          step_pulse     <= 1'b1;
          // save-I steps walk memory instead of running B
          execute_b_word <= (sel_q == SEL_B) && !save_i_switch;
          state_q        <= ST_WAIT;
        end
        ST_WAIT: begin
          if (instr_done || auto_mode) begin
            state_q <= ST_IDLE;
          end
        end
        ST_INIT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers B and I, selection, status
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || initialize_pulse) begin
      b_reg                 <= WORD_ZERO;
      i_reg                 <= WORD_ZERO;
      sel_q                 <= SEL_B;
      interrupt_permit_flag <= 1'b0;
      status_bits           <= {STATUS_INIT, 1'b1};
    end else begin
      if (reg_select_strobe && !auto_mode) begin
        sel_q <= reg_sel_t'(reg_select_in);
      end
      // digit for loader lands in bits 0-2 the same way
      if (entry_strobe && !auto_mode && sel_q == SEL_B) begin
        b_reg <= entry_bits;
      end
      if (state_q == ST_WAIT && instr_done && save_i_switch) begin
        i_reg <= WORD_W'(mem_addr_value);
      end
    end
  end

  // --------------------------------------------------------------
  // loader start on manual to automatic edge with loader selected
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      auto_prev_q  <= 1'b0;
      loader_start <= 1'b0;
    end else begin
      auto_prev_q  <= auto_mode;
      loader_start <= loader_select_switch && auto_mode &&
                      !auto_prev_q;
    end
  end

  // --------------------------------------------------------------
  // display
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      display_lamps    <= WORD_ZERO;
      reg_select_lamps <= SEL_B;
    end else begin
      reg_select_lamps <= sel_q;
      case (sel_q)
        SEL_A:   display_lamps <= a_reg_value;
        SEL_B:   display_lamps <= b_reg;
        SEL_I:   display_lamps <= i_reg;
        SEL_P:   display_lamps <= p_reg_value;
        default: display_lamps <= b_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // alarms; a new error in the clear cycle wins
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm_clear_pulse <= 1'b0;
      core_parity_q     <= 1'b0;
      io_alarm_q        <= 1'b0;
      io_buffer_lamp    <= 1'b0;
    end else begin
      alarm_clear_pulse <= manual_press(sw.press[SW_ACLR],
                                        auto_mode);
      if (core_parity_error) begin
        core_parity_q <= 1'b1;
      end else if (alarm_clear_pulse || initialize_pulse) begin
        core_parity_q <= 1'b0;
      end
      if (io_alarm) begin
        io_alarm_q <= 1'b1;
      end else if (alarm_clear_pulse || initialize_pulse) begin
        io_alarm_q <= 1'b0;
      end
      if (io_buffer_error) begin
        io_buffer_lamp <= 1'b1;
      end else if (jump_no_error_op || alarm_clear_pulse ||
                   initialize_pulse) begin
        io_buffer_lamp <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_stall_lamp <= 1'b0;
    end else if (watchdog_expired && !lockout) begin
      interrupt_stall_lamp <= 1'b1;
    end else if (trap_save_and_branch_op || initialize_pulse ||
                 lockout) begin
      interrupt_stall_lamp <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      general_alarm_lamp   <= 1'b0;
      cabinet_heat_lamp    <= 1'b0;
      instr_reg_stale_lamp <= 1'b0;
    end else begin
      general_alarm_lamp <= temp_warning || airflow_low ||
                            watchdog_trap || stall_alarm ||
                            core_parity_error || core_parity_q ||
                            core_temp_alarm || io_alarm || io_alarm_q;
      cabinet_heat_lamp  <= temp_warning || airflow_low;
      if (mul_div_table_op) begin
        instr_reg_stale_lamp <= 1'b1;
      end else if (instr_done || initialize_pulse) begin
        instr_reg_stale_lamp <= 1'b0;
      end
    end
  end

endmodule

//--- console_checker_properties.sv
`timescale 1ns/1ps
module console_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // switches
  input wire logic console_enable_key,
  input wire logic run_step_toggle,
  input wire logic interrupt_lockout_toggle,
  // processor events
  input wire logic watchdog_expired,
  input wire logic trap_save_and_branch_op,
  input wire logic jump_no_error_op,
  input wire logic mul_div_table_op,
  input wire logic instr_done,
  input wire logic io_buffer_error,
  // alarms
  input wire logic temp_warning,
  input wire logic airflow_low,
  input wire logic watchdog_trap,
  input wire logic stall_alarm,
  input wire logic core_parity_error,
  input wire logic core_temp_alarm,
  input wire logic io_alarm,
  // watched outputs
  input wire logic run_enable,
  input wire logic interrupt_enable,
  input wire logic watchdog_enable,
  input wire logic interrupt_stall_lamp,
  input wire logic general_alarm_lamp,
  input wire logic cabinet_heat_lamp,
  input wire logic instr_reg_stale_lamp,
  input wire logic io_buffer_lamp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // four cycles leave room for a synchronizer in front of the toggles
  sequence manual_held;
    (console_enable_key && !run_step_toggle) [*4];
  endsequence
  sequence auto_held;
    (console_enable_key && run_step_toggle) [*4];
  endsequence
  sequence key_off_held;
    (!console_enable_key) [*4];
  endsequence
  sequence lockout_held;
    (console_enable_key && interrupt_lockout_toggle) [*4];
  endsequence
  a_manual_halts: assert property (manual_held |-> !run_enable)
    else $error("run enabled in manual mode");
  a_auto_runs: assert property (auto_held |-> run_enable)
    else $error("run not enabled in auto mode");
  a_key_forces_auto: assert property (key_off_held |-> run_enable)
    else $error("disabled console did not force auto");
  a_key_enables_irq: assert property (key_off_held |->
    interrupt_enable && watchdog_enable)
    else $error("disabled console did not enable interrupts");
  a_lockout_inhibits: assert property (lockout_held |->
    !interrupt_enable && !watchdog_enable)
    else $error("lockout did not inhibit interrupts");
  a_stall_sets: assert property (watchdog_expired &&
    !interrupt_lockout_toggle |=> interrupt_stall_lamp)
    else $error("stall lamp not set on timeout");
  a_stall_clears: assert property (trap_save_and_branch_op &&
    !watchdog_expired |=> !interrupt_stall_lamp)
    else $error("stall lamp not cleared by trap");
  a_alarm_lights: assert property ((airflow_low || watchdog_trap ||
    stall_alarm || core_parity_error || core_temp_alarm || io_alarm)
    |=> general_alarm_lamp)
    else $error("general alarm lamp dark on alarm");
  a_heat_warns: assert property (temp_warning || airflow_low
    |=> cabinet_heat_lamp)
    else $error("cabinet heat lamp dark on warning");
  a_stale_sets: assert property (mul_div_table_op
    |=> instr_reg_stale_lamp)
    else $error("stale lamp not set");
  a_stale_clears: assert property (instr_done && !mul_div_table_op
    |=> !instr_reg_stale_lamp)
    else $error("stale lamp not cleared");
  a_iobuf_sets: assert property (io_buffer_error |=> io_buffer_lamp)
    else $error("io buffer lamp not set");
  a_iobuf_clears: assert property (jump_no_error_op &&
    !io_buffer_error |=> !io_buffer_lamp)
    else $error("io buffer lamp not cleared");
endmodule

bind console_control console_checker checker_inst (.*);

//--- console_operator.sv
`timescale 1ns/1ps
module console_operator (
  // clock
  input  wire logic                         clk,
  // switches and buttons
  output logic                              console_enable_key,
  output logic                              run_step_toggle,
  output logic                              step_button,
  output logic                              alarm_clear_button,
  output logic                              power_on_button,
  output logic                              interrupt_lockout_toggle,
  output logic                              save_i_switch,
  output logic                              loader_select_switch,
  output logic [1:0]                        reg_select_in,
  output logic                              reg_select_strobe,
  output logic [console_pkg::WORD_W-1:0]    entry_bits,
  output logic                              entry_strobe
);
  import console_pkg::*;
  // buttons stay released: a press needs far longer than one run
  initial begin
    {console_enable_key, run_step_toggle, step_button} = 3'h4;
    {alarm_clear_button, power_on_button, save_i_switch} = 3'h0;
    {interrupt_lockout_toggle, loader_select_switch} = 2'h0;
    {reg_select_in, reg_select_strobe, entry_strobe} = 4'h0;
    entry_bits = 24'h000000;
  end
  task set_sw(input logic key, input logic auto, input logic lock,
              input logic load);
    @(negedge clk);
    console_enable_key = key;
    run_step_toggle = auto;
    interrupt_lockout_toggle = lock;
    loader_select_switch = load;
  endtask
  task select(input logic [1:0] s);
    @(negedge clk);
    reg_select_in = s;
    reg_select_strobe = 1'b1;
    @(negedge clk);
    reg_select_strobe = 1'b0;
    reg_select_in = ~s;
  endtask
  task enter(input logic [WORD_W-1:0] w);
    @(negedge clk);
    entry_bits = w;
    entry_strobe = 1'b1;
    @(negedge clk);
    entry_strobe = 1'b0;
    entry_bits = ~w;
  endtask
endmodule

//--- test_console_control.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_console_control;
  import console_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic console_enable_key, run_step_toggle, step_button;
  logic alarm_clear_button, power_on_button, interrupt_lockout_toggle;
  logic save_i_switch, loader_select_switch, reg_select_strobe;
  logic entry_strobe;
  logic [1:0] reg_select_in;
  logic [WORD_W-1:0] entry_bits;
  logic [5:0] ev = 6'h00;
  logic [7:0] al = 8'h00;
  logic instr_done, watchdog_expired, trap_save_and_branch_op;
  logic jump_no_error_op, mul_div_table_op, io_buffer_error;
  logic temp_warning, airflow_low, temp_trip, watchdog_trap;
  logic stall_alarm, core_parity_error, core_temp_alarm, io_alarm;
  logic [WORD_W-1:0] a_reg_value = 24'h3c5a69;
  logic [WORD_W-1:0] p_reg_value = 24'h000123;
  logic [ADDR_W-1:0] mem_addr_value = 15'h0042;
  logic run_enable, step_pulse, execute_b_word, initialize_pulse;
  logic dc_power_on, interrupt_enable, watchdog_enable;
  logic interrupt_permit_flag, alarm_clear_pulse, loader_start;
  logic interrupt_stall_lamp, general_alarm_lamp, cabinet_heat_lamp;
  logic instr_reg_stale_lamp, io_buffer_lamp, seen;
  logic [WORD_W-1:0] b_reg, i_reg, display_lamps;
  logic [4:0] status_bits;
  logic [1:0] reg_select_lamps;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int order [6] = '{1, 3, 4, 6, 7, 5};
  assign {watchdog_expired, trap_save_and_branch_op, jump_no_error_op,
          mul_div_table_op, io_buffer_error, instr_done} = ev;
  assign {io_alarm, core_temp_alarm, core_parity_error, stall_alarm,
          watchdog_trap, temp_trip, airflow_low, temp_warning} = al;
  console_control console_control_inst (.*);
  console_operator console_operator_inst (.*);
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task give_verdict;
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev = 6'h00;
    repeat (2) @(negedge clk);
  endtask
  task mode(input logic k, input logic a, input logic l, input logic d);
    console_operator_inst.set_sw(k, a, l, d);
    repeat (5) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    `CHECK("status", 5'h01, status_bits)
    `CHECK("select", SEL_B, reg_select_lamps)
    `CHECK("b_reg", 24'h000000, b_reg)
    `CHECK("i_reg", 24'h000000, i_reg)
    `CHECK("permit", 1'b0, interrupt_permit_flag)
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    `CHECK("run manual", 1'b0, run_enable)
    `CHECK("irq open", 1'b1, interrupt_enable)
    mode(1'b1, 1'b1, 1'b0, 1'b0);
    `CHECK("run auto", 1'b1, run_enable)
    mode(1'b1, 1'b0, 1'b1, 1'b0);
    `CHECK("irq lockout", 1'b0, interrupt_enable)
    `CHECK("wdog lockout", 1'b0, watchdog_enable)
    mode(1'b0, 1'b0, 1'b1, 1'b0);
    `CHECK("run key off", 1'b1, run_enable)
    `CHECK("irq key off", 1'b1, interrupt_enable)
    `CHECK("wdog key off", 1'b1, watchdog_enable)
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    pulse(5);
    `CHECK("stall set", 1'b1, interrupt_stall_lamp)
    pulse(4);
    `CHECK("stall trap", 1'b0, interrupt_stall_lamp)
    pulse(5);
    mode(1'b1, 1'b0, 1'b1, 1'b0);
    `CHECK("stall lockout", 1'b0, interrupt_stall_lamp)
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    pulse(2);
    `CHECK("stale set", 1'b1, instr_reg_stale_lamp)
    pulse(0);
    `CHECK("stale clear", 1'b0, instr_reg_stale_lamp)
    pulse(1);
    `CHECK("iobuf set", 1'b1, io_buffer_lamp)
    pulse(3);
    `CHECK("iobuf clear", 1'b0, io_buffer_lamp)
    // io and parity alarms latch, so they go last and stay lit
    for (int k = 0; k < 6; k++) begin
      al = 8'h01 << order[k];
      repeat (3) @(negedge clk);
      `CHECK("alarm on", 1'b1, general_alarm_lamp)
      al = 8'h00;
      repeat (3) @(negedge clk);
      `CHECK("alarm off", (k >= 4), general_alarm_lamp)
    end
    al = 8'h01;
    repeat (3) @(negedge clk);
    `CHECK("heat warn", 1'b1, cabinet_heat_lamp)
    al = 8'h00;
    console_operator_inst.select(SEL_B);
    console_operator_inst.enter(24'h300007);
    repeat (3) @(negedge clk);
    `CHECK("b entry", 24'h300007, b_reg)
    `CHECK("b shown", 24'h300007, display_lamps)
    console_operator_inst.select(SEL_A);
    repeat (3) @(negedge clk);
    `CHECK("a shown", 24'h3c5a69, display_lamps)
    `CHECK("a lamps", SEL_A, reg_select_lamps)
    console_operator_inst.select(SEL_B);
    console_operator_inst.enter(24'h000003);
    mode(1'b1, 1'b0, 1'b0, 1'b1);
    seen = 1'b0;
    console_operator_inst.set_sw(1'b1, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      seen = seen | loader_start;
    end
    `CHECK("loader start", 1'b1, seen)
    `CHECK("loader digit", 3'h3, b_reg[2:0])
    // no press can pass the debounce window inside this run
    `CHECK("no step", 1'b0, step_pulse)
    `CHECK("no b exec", 1'b0, execute_b_word)
    `CHECK("no init", 1'b0, initialize_pulse)
    `CHECK("no power", 1'b0, dc_power_on)
    `CHECK("no clear", 1'b0, alarm_clear_pulse)
    give_verdict();
  end
endmodule
